//--- logic/i2cm_cfg.svh
// Purpose: Constants of the two-wire bus master channel.
// Assumes: 200 MHz system clock, Wishbone word index = printed offset.
// Notes:   Byte address on the bus is four times the index.
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH

// ****************************************
// Register indices
// ****************************************
`define I2CM_IDX_FSW   16'hFEE6
`define I2CM_IDX_MSTP  16'hFF87
`define I2CM_IDX_SERIAL_TIMER_CTRL  16'hFFC3
`define I2CM_IDX_BCTL  16'hFFD8
`define I2CM_IDX_BSTS  16'hFFD9
`define I2CM_IDX_DATA  16'hFFDE
`define I2CM_IDX_MODE  16'hFFDF

// ****************************************
// Field positions
// ****************************************
`define I2CM_B_ICE     7
`define I2CM_B_MST     5
`define I2CM_B_TRS     4
`define I2CM_B_ACK_CHECK_ENABLE    3
`define I2CM_B_BUS_BUSY    2
`define I2CM_B_INTERFACE_INT_FLAG    1
`define I2CM_B_SCP     0
`define I2CM_B_ACK_BIT    0
`define I2CM_B_MLS     7
`define I2CM_B_WAIT    6
`define I2CM_B_CKS     3
`define I2CM_B_IICX    5
`define I2CM_B_REGISTER_ACCESS_ENABLE    4
`define I2CM_B_SW      6
`define I2CM_B_CHSTOP  4
`define I2CM_B_FS      0

// ****************************************
// Reset values and codes
// ****************************************
`define I2CM_RST_MSTP  8'hFF
`define I2CM_CKS_100K  3'h5
`define I2CM_CLR_ALL   4'hF

// ****************************************
// Timing
// ****************************************
`define I2CM_CLK_KHZ   200000
`define I2CM_SCL_KHZ   100
`define I2CM_QTR_CYC   (`I2CM_CLK_KHZ / (4 * `I2CM_SCL_KHZ))

`endif

//--- logic/i2cm_pkg.sv
// Purpose: Types of the two-wire bus master channel.
// Assumes: Nothing beyond the constants header.
// Notes:   All state of i2cm_top except the pin synchroniser lives in one packed struct.
package i2cm_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,  // Bus idle or clock held low
    ST_START = 3'h1,  // Start or repeated start
    ST_BIT   = 3'h2,  // Frame bits
    ST_HOLD  = 3'h3,  // Wait before acknowledge
    ST_STOP  = 3'h4   // Stop condition
  } i2cm_state_type;

  // ****************************************
  // Whole state of the channel
  // ****************************************
  typedef struct packed {
    i2cm_state_type st;
    logic [1:0]     qtr;    // Quarter of bit period
    logic [10:0]    cnt;    // Quarter down counter
    logic [3:0]     bitn;   // Bit index in frame
    logic [7:0]     shift;  // Shift data
    logic           scl_low;
    logic           sda_low;
    logic [2:0]     fsw;    // Switch enable, select, irq enable
    logic [7:0]     mstp;
    logic [7:0]     serial_timer_ctrl;
    logic           interface_enable;
    logic           interrupt_enable;
    logic           mst;
    logic           trs;
    logic           ack_check_enable;
    logic           interface_int_flag;
    logic           busy;
    logic           ack_bit;
    logic           halt;   // Transmit stopped by nack
    logic [7:0]     oadr;
    logic [7:0]     oadr2;
    logic [7:0]     tmode;
    logic           wb_ack;
    logic [7:0]     rdat;
    logic           scl_p;  // Previous synced levels
    logic           sda_p;
  } i2cm_regs_type;

endpackage

//--- logic/i2cm_sync.sv
// Purpose: Two-stage synchroniser for pin levels.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   Resets to ones, the idle level of a pulled-up bus.
`timescale 1ns/1ps
module i2cm_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [WIDTH-1:0] meta;  // First stage, read only by second
    logic [WIDTH-1:0] stab;  // Second stage
  } i2cm_sync_type;

  i2cm_sync_type s_reg;
  i2cm_sync_type s_next;

  if (WIDTH < 1) begin : g_bad_width
    $error("i2cm_sync: WIDTH must be at least 1");
  end

  // Next state
  always_comb begin
    s_next      = s_reg;
    s_next.meta = d_i;
    s_next.stab = s_reg.meta;
  end

  // Register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.stab;
endmodule

//--- logic/i2cm_top.sv
// Purpose: Two-wire bus master channel with Wishbone registers.
// Assumes: Open-drain pins resolved outside; pins asynchronous.
// Notes:   Software sequences start, frames and stop.
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module i2cm_top import i2cm_pkg::*; #(
  parameter int ADR_W = 18
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [31:0]      dat_i,
  input  wire logic             we_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe_o,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o
);
  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [10:0] QTR_CYC = 11'(`I2CM_QTR_CYC);

  i2cm_regs_type s_reg;    // All state
  i2cm_regs_type s_next;   // Next state
  logic [1:0]    pin_s;    // Synced {scl, sda}
  logic          scl_s;
  logic          sda_s;
  logic          req;      // Bus request pending
  logic          wr;       // Write at ack edge
  logic          rd;       // Read at ack edge
  logic [15:0]   idx;      // Word index
  logic          acc_ok;   // Controller regs reachable
  logic [7:0]    rmux;     // Read mux
  logic          run;      // Channel may drive bus
  logic          fmt_ok;   // Standard bus format selected
  logic [10:0]   qlen;     // Quarter length
  logic          tick;     // Quarter ends
  logic          stretch;  // Slave holds clock low
  logic [3:0]    dbits;    // Data bits per frame
  logic          is_ack;   // Current bit is acknowledge
  logic          txbit;    // Next bit to send
  logic          go_start;
  logic          go_stop;
  logic          go_frame;
  logic          clr_all;

  if (ADR_W < 18) begin : g_bad_adr
    $error("i2cm_top: ADR_W must be at least 18");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  i2cm_sync #(.WIDTH(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // ****************************************
  // Decode and derived controls
  // ****************************************
  assign req    = cyc_i & stb_i;
  assign wr     = req & we_i & s_reg.wb_ack & sel_i[0];
  assign rd     = req & ~we_i & s_reg.wb_ack;
  assign idx    = adr_i[17:2];
  assign acc_ok = s_reg.serial_timer_ctrl[`I2CM_B_REGISTER_ACCESS_ENABLE];
  assign fmt_ok = ~s_reg.oadr[`I2CM_B_FS]
                & s_reg.oadr2[`I2CM_B_FS]
                & ~s_reg.fsw[1];
  assign run    = s_reg.interface_enable & fmt_ok
                & ~s_reg.mstp[`I2CM_B_CHSTOP];
  // 100 kHz code with IICX set; any other setting runs at half that rate
  assign qlen   = (s_reg.tmode[5:3] == `I2CM_CKS_100K
                   && s_reg.serial_timer_ctrl[`I2CM_B_IICX]) ?
                  QTR_CYC : 11'(2 * QTR_CYC);
  assign stretch = ~s_reg.scl_low & ~scl_s;
  assign tick    = (s_reg.cnt == 11'h000) & ~stretch;
  assign dbits   = (s_reg.tmode[2:0] == 3'h0) ? 4'h8
                 : {1'b0, s_reg.tmode[2:0]};
  assign is_ack  = (s_reg.bitn == dbits);
  assign clr_all = wr & (idx == `I2CM_IDX_FSW)
                 & (dat_i[3:0] == `I2CM_CLR_ALL);

  // Read mux, overlapping locations follow interface enable
  always_comb begin
    rmux = 8'h00;
    case (idx)
      `I2CM_IDX_FSW:  rmux = {s_reg.fsw, 5'h00};
      `I2CM_IDX_MSTP: rmux = s_reg.mstp;
      `I2CM_IDX_SERIAL_TIMER_CTRL: rmux = s_reg.serial_timer_ctrl;
      `I2CM_IDX_BCTL: rmux = {s_reg.interface_enable, s_reg.interrupt_enable, s_reg.mst,
                              s_reg.trs, s_reg.ack_check_enable, s_reg.busy,
                              s_reg.interface_int_flag, 1'b1};
      `I2CM_IDX_BSTS: rmux = {7'h00, s_reg.ack_bit};
      `I2CM_IDX_DATA: rmux = s_reg.interface_enable ? s_reg.shift
                                       : s_reg.oadr2;
      `I2CM_IDX_MODE: rmux = s_reg.interface_enable ? s_reg.tmode : s_reg.oadr;
      default:        rmux = 8'h00;
    endcase
    if (!acc_ok && idx != `I2CM_IDX_FSW && idx != `I2CM_IDX_MSTP
        && idx != `I2CM_IDX_SERIAL_TIMER_CTRL) begin
      rmux = 8'h00;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next   = s_reg;
    go_start = 1'b0;
    go_stop  = 1'b0;
    go_frame = 1'b0;
    txbit    = s_reg.tmode[`I2CM_B_MLS] ? s_reg.shift[0]
                                        : s_reg.shift[7];
    // Bus handshake: ack one cycle after request, one cycle long
    s_next.wb_ack = req & ~s_reg.wb_ack;
    if (req && !s_reg.wb_ack) begin
      s_next.rdat = rmux;
    end
    s_next.scl_p = scl_s;
    s_next.sda_p = sda_s;

    // Register writes
    if (wr) begin
      case (idx)
        `I2CM_IDX_FSW:  s_next.fsw  = dat_i[7:5];
        `I2CM_IDX_MSTP: s_next.mstp = dat_i[7:0];
        `I2CM_IDX_SERIAL_TIMER_CTRL: s_next.serial_timer_ctrl = dat_i[7:0];
        default: ;
      endcase
      if (acc_ok) begin
        case (idx)
          `I2CM_IDX_BCTL: begin
            s_next.interface_enable  = dat_i[`I2CM_B_ICE];
            s_next.interrupt_enable = dat_i[6];
            s_next.mst  = dat_i[`I2CM_B_MST];
            s_next.trs  = dat_i[`I2CM_B_TRS];
            s_next.ack_check_enable = dat_i[`I2CM_B_ACK_CHECK_ENABLE];
            if (!dat_i[`I2CM_B_INTERFACE_INT_FLAG]) begin
              s_next.interface_int_flag = 1'b0;
            end
            // Protect bit low arms start or stop
            if (!dat_i[`I2CM_B_SCP] && s_reg.st == ST_IDLE
                && dat_i[`I2CM_B_MST] && run) begin
              go_start = dat_i[`I2CM_B_BUS_BUSY];
              go_stop  = ~dat_i[`I2CM_B_BUS_BUSY];
            end
          end
          `I2CM_IDX_BSTS: s_next.ack_bit = dat_i[`I2CM_B_ACK_BIT];
          `I2CM_IDX_DATA: begin
            if (s_reg.interface_enable) begin
              // Software loads A0h, 00h, A1h here
              s_next.shift = dat_i[7:0];
              go_frame = s_reg.trs & ~s_reg.halt;
            end else begin
              s_next.oadr2 = dat_i[7:0];
            end
          end
          `I2CM_IDX_MODE: begin
            if (s_reg.interface_enable) begin
              s_next.tmode = dat_i[7:0];
            end else begin
              s_next.oadr = dat_i[7:0];
            end
          end
          default: ;
        endcase
      end
    end
    // Reading data in receive mode starts the next frame
    if (rd && acc_ok && idx == `I2CM_IDX_DATA && s_reg.interface_enable
        && !s_reg.trs) begin
      go_frame = 1'b1;
    end
    go_frame = go_frame & s_reg.mst & s_reg.busy & run
             & (s_reg.st == ST_IDLE);

    // Bus condition detection, set wins over a bus_ctrl flag clear but not over the FSW clear-all
    if (s_reg.scl_p && scl_s && s_reg.sda_p && !sda_s) begin
      s_next.busy = 1'b1;
      // Own start flags only once its sequence is complete
      if (s_reg.st != ST_START) begin
        s_next.interface_int_flag = 1'b1;
      end
    end
    if (s_reg.scl_p && scl_s && !s_reg.sda_p && sda_s) begin
      s_next.busy = 1'b0;
    end

    // Quarter counter
    if (s_reg.st != ST_IDLE && s_reg.st != ST_HOLD) begin
      if (tick) begin
        s_next.cnt = qlen - 11'h001;
        s_next.qtr = s_reg.qtr + 2'h1;
      end else if (!stretch) begin
        s_next.cnt = s_reg.cnt - 11'h001;
      end
    end

    // Sequencer
    case (s_reg.st)
      ST_IDLE: begin
        if (go_start) begin
          // Repeated start works from a held-low clock
          s_next.st      = ST_START;
          s_next.halt    = 1'b0;
          s_next.scl_low = 1'b1;
          s_next.sda_low = 1'b0;
        end else if (go_stop) begin
          s_next.st      = ST_STOP;
          s_next.scl_low = 1'b1;
          s_next.sda_low = 1'b1;
        end else if (go_frame) begin
          s_next.st      = ST_BIT;
          s_next.bitn    = 4'h0;
          s_next.sda_low = s_reg.trs & ~(s_reg.tmode[`I2CM_B_MLS] ?
                           s_next.shift[0] : s_next.shift[7]);
        end
        s_next.qtr = 2'h0;
        s_next.cnt = qlen - 11'h001;
      end
      ST_START: begin
        if (tick) begin
          case (s_reg.qtr)
            2'h0: s_next.scl_low = 1'b0;
            2'h1: s_next.sda_low = 1'b1;
            2'h2: s_next.scl_low = 1'b1;
            default: begin
              s_next.st      = ST_IDLE;
              s_next.sda_low = 1'b0;
              s_next.interface_int_flag    = 1'b1;
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          case (s_reg.qtr)
            2'h0: s_next.scl_low = 1'b0;
            2'h1: s_next.sda_low = 1'b0;
            2'h2: ;
            default: s_next.st = ST_IDLE;
          endcase
        end
      end
      ST_BIT: begin
        if (tick) begin
          case (s_reg.qtr)
            // Data moves a quarter after the clock fell, never with it
            2'h0: begin
              if (is_ack) begin
                s_next.sda_low = ~s_reg.trs & ~s_reg.ack_bit;
              end else begin
                s_next.sda_low = s_reg.trs & ~txbit;
              end
            end
            2'h1: s_next.scl_low = 1'b0;
            2'h2: begin
              if (is_ack) begin
                if (s_reg.trs) begin
                  s_next.ack_bit = sda_s;
                end
              end else if (s_reg.tmode[`I2CM_B_MLS]) begin
                s_next.shift = {sda_s, s_reg.shift[7:1]};
              end else begin
                s_next.shift = {s_reg.shift[6:0], sda_s};
              end
            end
            2'h3: begin
              s_next.scl_low = 1'b1;
              if (is_ack) begin
                s_next.st      = ST_IDLE;
                s_next.interface_int_flag    = 1'b1;
                if (s_reg.trs && s_reg.ack_check_enable && s_reg.ack_bit) begin
                  s_next.halt = 1'b1;
                end
              end else begin
                s_next.bitn = s_reg.bitn + 4'h1;
                if (s_reg.bitn + 4'h1 == dbits
                    && s_reg.tmode[`I2CM_B_WAIT]) begin
                  s_next.st   = ST_HOLD;
                  s_next.interface_int_flag = 1'b1;
                end
              end
            end
            default: ;
          endcase
        end
      end
      ST_HOLD: begin
        // Clock stays low until software clears the flag
        if (!s_next.interface_int_flag) begin
          s_next.st      = ST_BIT;
          s_next.qtr     = 2'h0;
          s_next.cnt     = qlen - 11'h001;
          s_next.sda_low = ~s_reg.trs & ~s_reg.ack_bit;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    // Channel off or cleared: release everything
    if (!run || clr_all) begin
      s_next.st      = ST_IDLE;
      s_next.scl_low = 1'b0;
      s_next.sda_low = 1'b0;
      s_next.bitn    = 4'h0;
      s_next.halt    = 1'b0;
    end
    if (clr_all) begin
      s_next.busy = 1'b0;
      s_next.interface_int_flag = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg      <= '0;
      s_reg.mstp <= `I2CM_RST_MSTP;
      // Idle bus level, so no false edge follows reset
      s_reg.scl_p <= 1'b1;
      s_reg.sda_p <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dat_o    = {24'h000000, s_reg.rdat};
  assign ack_o    = s_reg.wb_ack;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = s_reg.scl_low;
  assign sda_oe_o = s_reg.sda_low;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_wb_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_pins_released: assert property (
    !s_reg.interface_enable |=> !scl_oe_o && !sda_oe_o)
    else $error("pins driven with interface disabled");
  chk_access_gate: assert property (
    req && !ack_o && !acc_ok && idx == `I2CM_IDX_BCTL
    |=> ack_o && dat_o == 32'h00000000)
    else $error("control register visible without access enable");
  chk_quarter_bound: assert property (
    s_reg.st == ST_BIT |-> s_reg.cnt < 11'(2 * QTR_CYC))
    else $error("quarter counter beyond period");
  chk_quarter_hold: assert property (
    s_reg.st == ST_BIT && s_reg.cnt != 11'h000
    |=> s_reg.qtr == $past(s_reg.qtr))
    else $error("quarter advanced early");
  chk_msb_first: assert property (
    s_reg.st == ST_BIT && s_reg.trs && !is_ack && s_reg.qtr == 2'h1
    && !s_reg.tmode[`I2CM_B_MLS] && s_reg.bitn == 4'h0
    && $past(s_reg.st) == ST_IDLE |-> sda_oe_o == !s_reg.shift[7])
    else $error("first bit not most significant");
  chk_hold_clock: assert property (
    s_reg.st == ST_HOLD |-> scl_oe_o && s_reg.interface_int_flag)
    else $error("clock not held in wait");
  chk_nack_halt: assert property (
    s_reg.halt && s_reg.st == ST_IDLE && !go_start
    |=> s_reg.st != ST_BIT)
    else $error("transmit frame after nack halt");
  chk_flag_set_wins: assert property (
    s_reg.st == ST_BIT && tick && s_reg.qtr == 2'h3 && is_ack
    && run && !clr_all |=> s_reg.interface_int_flag)
    else $error("frame end flag lost");
  chk_clear_state: assert property (
    clr_all |=> s_reg.st == ST_IDLE && !s_reg.busy && !scl_oe_o)
    else $error("clear did not reset channel");
  chk_start_edge: assert property (
    s_reg.st == ST_START && s_reg.qtr == 2'h2 |-> sda_oe_o && !scl_oe_o)
    else $error("start edge with clock low");

  cov_start: cover property (s_reg.st == ST_START ##1 s_reg.st == ST_IDLE);
  cov_frame: cover property (s_reg.st == ST_BIT && is_ack && tick);
  cov_hold:  cover property (s_reg.st == ST_HOLD);
  cov_stop:  cover property (s_reg.st == ST_STOP ##1 s_reg.st == ST_IDLE);
endmodule

//--- verification/i2cm_eeprom.sv
// Purpose: Behavioural serial memory answering the bus master.
// Assumes: Wires are pulled up; this model never stretches SCL.
// Notes:   Every location reads back DATA; no address increment.
`timescale 1ns/1ps
module i2cm_eeprom #(
  parameter logic [7:0] DATA = 8'hC5  // Contents returned on reads
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_low_o
);
  logic [7:0] sh    = 8'h00;  // Incoming shift
  logic [7:0] got[$];         // Bytes written by the master
  logic       rd    = 1'b0;   // Read phase
  logic       act   = 1'b0;   // Inside a transfer
  logic       mack  = 1'b0;   // Last acknowledge from master
  int         n     = 0;      // Bit index in frame
  int         fr    = 0;      // Frames since start
  int         stops = 0;      // Stop conditions seen
  initial sda_low_o = 1'b0;
  // Start or repeated start
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    n = 0;
    fr = 0;
    rd = 1'b0;
    act = 1'b1;
  end
  // Stop condition
  always @(posedge sda_i) if (scl_i === 1'b1 && act) begin
    stops++;
    act = 1'b0;
  end
  // Sample on rising SCL, MSB first
  always @(posedge scl_i) if (act) begin
    if (n < 8) sh = {sh[6:0], sda_i};
    else if (rd) mack = sda_i;
    n++;
  end
  // Drive on falling SCL
  always @(negedge scl_i) if (act) begin
    if (n == 8) begin
      if (!rd) got.push_back(sh);
      sda_low_o = !rd && (fr > 0 || sh[7:1] == 7'h50);
      if (fr == 0) rd = sh[0];
      fr++;
    end else if (n == 9) begin
      n = 0;
      sda_low_o = rd & ~mack & ~DATA[7];
    end else if (rd && n > 0) begin
      sda_low_o = ~DATA[7-n];
    end
  end
endmodule

//--- verification/tb_top.sv
// Purpose: Bench reading one byte from the memory model.
// Assumes: Register writes use the low byte lane only.
// Notes:   Sequence shortened to four frames to bound run time.
`timescale 1ns/1ps
module tb_top;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic [17:0] adr_i    = '0;
  logic [31:0] dat_i    = '0;
  logic        we_i     = 1'b0;
  logic [3:0]  sel_i    = 4'h0;
  logic        cyc_i    = 1'b0;
  logic        stb_i    = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        scl_oe_o;
  logic        sda_oe_o;
  logic        sda_low;
  wire         scl      = ~scl_oe_o;            // Pulled-up clock
  wire         sda      = ~(sda_oe_o | sda_low);  // Wired-and data
  int          failures = 0;
  int          checks   = 0;
  time         tp[$];                           // SCL rise times
  logic [7:0]  q;
  i2cm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl), .scl_o(),
    .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o));
  i2cm_eeprom i_mem (.scl_i(scl), .sda_i(sda), .sda_low_o(sda_low));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge scl) tp.push_back($time);
  // Compare and count
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle
  task automatic wb(input logic [15:0] idx, input logic w,
                    input logic [7:0] d, output logic [7:0] r);
    int t;
    t = 0;
    @(posedge clk_i);
    adr_i <= {idx, 2'b00};
    we_i  <= w;
    dat_i <= {24'h0, d};
    sel_i <= 4'h1;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 100);
    if (ack_o !== 1'b1) failures++;
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(idx, 1'b1, d, r);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    logic [7:0] r;
    wb(idx, 1'b0, 8'h00, r);
    cmp(r, e);
  endtask
  // Poll a bus_ctrl bit until it reaches a level
  task automatic wait_bit(input int b, input logic v);
    int n;
    logic [7:0] r;
    n = 0;
    do begin
      wb(16'hFFD8, 1'b0, 8'h00, r);
      n++;
    end while (r[b] !== v && n < 20000);
    cmp({7'h0, r[b]}, {7'h0, v});
  endtask
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog, a quarter beyond the expected run
  initial begin
    #490000;
    failures++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(16'hFF87, 8'hFF);
    rd(16'h0000, 8'h00);
    wr(16'hFFDF, 8'h55);
    rd(16'hFFDF, 8'h00);
    rd(16'hFFD8, 8'h00);
    wr(16'hFF87, 8'hEF);
    wr(16'hFFC3, 8'h10);
    wr(16'hFEE6, 8'h0F);
    rd(16'hFEE6, 8'h00);
    wr(16'hFFD8, 8'h01);
    wr(16'hFFDF, 8'h00);
    wr(16'hFFDE, 8'h01);
    wr(16'hFFD8, 8'h81);
    wr(16'hFFC3, 8'h30);
    wr(16'hFFDF, 8'h28);
    rd(16'hFFDF, 8'h28);
    wr(16'hFFD8, 8'h89);
    $display("test setup done");
    wr(16'hFFD8, 8'hBC);
    wait_bit(1, 1'b1);
    wait_bit(2, 1'b1);
    wr(16'hFFDE, 8'hA0);
    wr(16'hFFD8, 8'hB5);
    wait_bit(1, 1'b1);
    rd(16'hFFD9, 8'h00);
    q = {7'h0, tp[$] - tp[$-1] inside {[9990:10050]}};
    cmp(q, 8'h01);
    wr(16'hFFDF, 8'h68);  // Wait before acknowledge
    wr(16'hFFDE, 8'h00);
    wr(16'hFFD8, 8'hB5);
    wait_bit(1, 1'b1);
    wr(16'hFFD8, 8'hB5);
    wait_bit(1, 1'b1);
    rd(16'hFFD9, 8'h00);
    wr(16'hFFDF, 8'h28);
    wr(16'hFFD8, 8'hB5);
    wr(16'hFFD8, 8'hBC);
    wait_bit(1, 1'b1);
    wr(16'hFFDE, 8'hA1);
    wr(16'hFFD8, 8'hB5);
    wait_bit(1, 1'b1);
    rd(16'hFFD9, 8'h00);
    $display("test address phase done");
    wr(16'hFFD9, 8'h01);
    wr(16'hFFD8, 8'hA5);
    wb(16'hFFDE, 1'b0, 8'h00, q);
    wait_bit(1, 1'b1);
    wr(16'hFFD8, 8'hB8);
    wait_bit(2, 1'b0);
    rd(16'hFFDE, 8'hC5);
    cmp(i_mem.got[0], 8'hA0);
    cmp(i_mem.got[1], 8'h00);
    cmp(i_mem.got[2], 8'hA1);
    cmp({7'h0, i_mem.mack}, 8'h01);
    cmp(8'(i_mem.stops), 8'h01);
    $display("test read phase done");
    report_and_stop();
  end
endmodule
